/* File: spi_eeprom_pkg.sv */
// Purpose: Shared constants and types of the serial EEPROM command engine
// Assumes: Core clock of 200 MHz; serial clock runs only inside a frame
// Notes: Op-codes, status layout, bit counts and write timing live here
package spi_eeprom_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Op-codes
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_STATUS_READ = 8'h05;
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01;

	////////////////////////////////////////////////////////////////////////////
	// Array and status layout
	localparam int ADDR_BITS = 13;
	localparam int ST_BUSY = 0;
	localparam int ST_WEL = 1;
	localparam int ST_BP_LO = 2;
	localparam int ST_BP_HI = 3;
	localparam int ST_HWPE = 7;
	localparam logic RESET_WEL = 1'b0;
	localparam logic [1:0] RESET_BLOCK_PROTECT = 2'h0;
	localparam logic RESET_HWPE = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	// Bit counts within a frame
	localparam logic [4:0] CNT_ZERO = 5'h00;
	localparam logic [4:0] CNT_OP_LAST = 5'h07;
	localparam logic [4:0] CNT_OP_DONE = 5'h08;
	localparam logic [4:0] CNT_ST_LAST = 5'h0f;
	localparam logic [4:0] CNT_SW_DONE = 5'h10;
	localparam logic [4:0] CNT_ADDR_LAST = 5'h17;
	localparam logic [4:0] CNT_DATA_FIRST = 5'h18;
	localparam logic [4:0] CNT_DATA_LAST = 5'h1f;

	////////////////////////////////////////////////////////////////////////////
	// Self-timed write
	localparam int WRITE_TIME_NS = 5000000;
	localparam int CORE_PERIOD_NS = 5;
	localparam int WRITE_CYCLES_DEFAULT = WRITE_TIME_NS / CORE_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [2:0] {
		CMD_NONE = 3'b000,
		CMD_READ = 3'b001,
		CMD_STATUS_READ = 3'b010,
		CMD_WRITE_ENABLE = 3'b011,
		CMD_WRITE_DISABLE = 3'b100,
		CMD_STATUS_WRITE = 3'b101
	} cmd_t;

	typedef enum logic [0:0] {
		CORE_IDLE = 1'b0,
		CORE_PROGRAM = 1'b1
	} core_phase_t;

	typedef struct packed {
		logic frame_tog;
		logic write_enable_cmd;
		logic wrdi;
		logic wrsr;
		logic [7:0] data;
	} link_flags_t;

	typedef struct packed {
		cmd_t cmd;
		logic [4:0] cnt;
		logic [7:0] opcode;
		logic [14:0] addr_hi;
		logic [ADDR_BITS-1:0] ptr;
		logic [7:0] status;
		logic [7:0] wr_data;
		logic [7:0] st_meta;
		logic [7:0] st_sync;
		link_flags_t flags;
	} link_state_t;

	typedef struct packed {
		logic cs_meta;
		logic cs_sync;
		logic cs_prev;
		logic wp_meta;
		logic wp_sync;
		logic wp_prev;
		link_flags_t fl_meta;
		link_flags_t fl_sync;
		core_phase_t phase;
		logic write_enable_latch;
		logic block_protect_lo;
		logic block_protect_hi;
		logic hw_protect_enable;
		logic wp_fell;
		logic tog_seen;
		logic [7:0] pend;
		logic [31:0] wait_cnt;
	} core_state_t;

endpackage : spi_eeprom_pkg

/* File: spi_eeprom_array.sv */
// Purpose: Two-clock byte array, preload port on core clock, read on serial clock
// Assumes: Preload never targets a byte being read in the same instant
// Notes: Read data come out of a register
`timescale 1ns/100ps
module spi_eeprom_array #(
	parameter int ADDR_W = 13,
	parameter int DATA_W = 8
) (
	// Write side
	input wire logic i_wr_clk,
	input wire logic i_wr_en,
	input wire logic [ADDR_W-1:0] i_wr_addr,
	input wire logic [DATA_W-1:0] i_wr_data,
	// Read side
	input wire logic i_rd_clk,
	input wire logic i_rd_en,
	input wire logic [ADDR_W-1:0] i_rd_addr,
	output logic [DATA_W-1:0] o_rd_data
);
	logic [DATA_W-1:0] mem [2**ADDR_W];

	always_ff @(posedge i_wr_clk) begin
		if (i_wr_en) begin
			mem[i_wr_addr] <= i_wr_data;
		end
	end

	always_ff @(posedge i_rd_clk) begin
		if (i_rd_en) begin
			o_rd_data <= mem[i_rd_addr];
		end
	end
endmodule : spi_eeprom_array

/* File: spi_eeprom_read_hold_protect.sv */
// Purpose: Serial slave command engine: array read, status read/write, hold, protect
// Assumes: Serial clock is the link clock; mode (0,0) or (1,1)
// Notes: Link flags cross on chip select rise, when the serial clock is quiet
`timescale 1ns/100ps

// Notes on behaviour
// - Status write refused while protect pin low and protect enable set.
// - Protect pin falling during a selected status write aborts it when protect enable set.
// - Once the self-timed status write starts, the protect pin has no effect.
// - With protect enable clear, the protect pin is ignored.
// - Data byte shifts out right after the last address bit.
// - Read pointer advances per byte while clocking continues.
// - Pointer wraps from the top address to zero.
// - Read ends only at select rise; output then released.
// - Status read shifts out eight status bits after the op-code.
// - Status read answered at any time, even during a write.
// - During hold the output floats and input bits are ignored.
// - Power-up leaves the write enable latch clear, idle.
// - Write enable latch clears after a completed write.
// - Internal write starts only on select rise after exact bit count.
// - Commands other than status read ignored during a write.
// - Unknown op-code ignores the frame, output stays floating.
// - Eight-bit op-codes decoded from the first byte after select.
// - Status: busy bit 0, latch 1, block protect 2-3, enable 7.
// - Only the low 13 address bits are used.
// - Input sampled on rising clock, output changed on falling clock.
module spi_eeprom_read_hold_protect #(
	parameter int WRITE_CYCLES = spi_eeprom_pkg::WRITE_CYCLES_DEFAULT
) (
	// Core clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// Serial pins
	input wire logic i_sck,
	input wire logic i_cs_n,
	input wire logic i_si,
	input wire logic i_hold_n,
	input wire logic i_wp_n,
	output logic o_so,
	output logic o_so_oe,
	// Array preload, core clock
	input wire logic i_load_en,
	input wire logic [spi_eeprom_pkg::ADDR_BITS-1:0] i_load_addr,
	input wire logic [7:0] i_load_data,
	// Status
	output logic [7:0] o_status,
	output logic o_busy
);
	if (WRITE_CYCLES < 2) begin : g_check
		$error("WRITE_CYCLES must be at least 2");
	end

	////////////////////////////////////////////////////////////////////////////
	// Core domain state
	spi_eeprom_pkg::core_state_t core;
	spi_eeprom_pkg::core_state_t next_core;
	spi_eeprom_pkg::link_state_t link;
	spi_eeprom_pkg::link_state_t next_link;
	logic [7:0] status_word;
	logic frame_start;
	logic frame_end;
	logic frame_fresh;
	logic hw_prot;
	logic sw_allowed;

	assign status_word = {core.hw_protect_enable, 3'h0, core.block_protect_hi,
		core.block_protect_lo, core.write_enable_latch,
		core.phase == spi_eeprom_pkg::CORE_PROGRAM};
	assign o_status = status_word;
	assign o_busy = core.phase == spi_eeprom_pkg::CORE_PROGRAM;
	assign frame_start = core.cs_prev & ~core.cs_sync;
	assign frame_end = core.cs_sync & ~core.cs_prev;
	// Frame end that follows at least one serial clock
	assign frame_fresh = frame_end && core.fl_sync.frame_tog != core.tog_seen;
	assign hw_prot = core.hw_protect_enable & ~core.wp_sync;
	assign sw_allowed = core.write_enable_latch & ~hw_prot
		& ~(core.wp_fell & core.hw_protect_enable);

	always_comb begin
		next_core = core;
		next_core.cs_meta = i_cs_n;
		next_core.cs_sync = core.cs_meta;
		next_core.cs_prev = core.cs_sync;
		next_core.wp_meta = i_wp_n;
		next_core.wp_sync = core.wp_meta;
		next_core.wp_prev = core.wp_sync;
		next_core.fl_meta = link.flags;
		next_core.fl_sync = core.fl_meta;
		if (frame_end) begin
			next_core.tog_seen = core.fl_sync.frame_tog;
		end
		if (frame_start) begin
			next_core.wp_fell = 1'b0;
		end
		if (~core.cs_sync && core.wp_prev && ~core.wp_sync) begin
			next_core.wp_fell = 1'b1;
		end
		unique case (core.phase)
			spi_eeprom_pkg::CORE_IDLE: begin
				if (frame_fresh) begin
					if (core.fl_sync.write_enable_cmd) begin
						next_core.write_enable_latch = 1'b1;
					end
					if (core.fl_sync.wrdi) begin
						next_core.write_enable_latch = 1'b0;
					end
					if (core.fl_sync.wrsr && sw_allowed) begin
						next_core.pend = core.fl_sync.data;
						next_core.wait_cnt = 32'(WRITE_CYCLES - 1);
						next_core.phase = spi_eeprom_pkg::CORE_PROGRAM;
					end
				end
			end
			spi_eeprom_pkg::CORE_PROGRAM: begin
				// Protect pin no longer consulted here
				if (core.wait_cnt == 32'h0000_0000) begin
					next_core.block_protect_lo = core.pend[spi_eeprom_pkg::ST_BP_LO];
					next_core.block_protect_hi = core.pend[spi_eeprom_pkg::ST_BP_HI];
					next_core.hw_protect_enable = core.pend[spi_eeprom_pkg::ST_HWPE];
					next_core.write_enable_latch = 1'b0;
					next_core.phase = spi_eeprom_pkg::CORE_IDLE;
				end else begin
					next_core.wait_cnt = core.wait_cnt - 32'h0000_0001;
				end
			end
		endcase
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			core <= '0;
			core.cs_meta <= 1'b1;
			core.cs_sync <= 1'b1;
			core.cs_prev <= 1'b1;
			core.wp_meta <= 1'b1;
			core.wp_sync <= 1'b1;
			core.wp_prev <= 1'b1;
			core.phase <= spi_eeprom_pkg::CORE_IDLE;
			core.write_enable_latch <= spi_eeprom_pkg::RESET_WEL;
			core.block_protect_lo <= spi_eeprom_pkg::RESET_BLOCK_PROTECT[0];
			core.block_protect_hi <= spi_eeprom_pkg::RESET_BLOCK_PROTECT[1];
			core.hw_protect_enable <= spi_eeprom_pkg::RESET_HWPE;
		end else begin
			core <= next_core;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Link domain: shifting on the serial clock
	logic armed;
	logic [4:0] bits;
	logic [7:0] op_now;
	logic rd_en;
	logic [spi_eeprom_pkg::ADDR_BITS-1:0] rd_addr;
	logic [7:0] rd_data;
	logic out_active;
	logic so_bit;
	logic so_drive;

	// Set while deselected; first rising edge of a frame clears it
	always_ff @(posedge i_sck or posedge i_rst or posedge i_cs_n) begin
		if (i_rst || i_cs_n) begin
			armed <= 1'b1;
		end else begin
			armed <= 1'b0;
		end
	end

	always_comb begin
		next_link = link;
		rd_en = 1'b0;
		rd_addr = link.ptr;
		bits = armed ? spi_eeprom_pkg::CNT_ZERO : link.cnt;
		op_now = {link.opcode[6:0], i_si};
		next_link.st_meta = status_word;
		next_link.st_sync = link.st_meta;
		if (armed) begin
			next_link.cmd = spi_eeprom_pkg::CMD_NONE;
		end
		// Marks a frame that saw a clock, so stale flags never act twice
		if (armed && !i_cs_n) begin
			next_link.flags.frame_tog = ~link.flags.frame_tog;
		end
		if (i_hold_n) begin
			if (bits <= spi_eeprom_pkg::CNT_OP_LAST) begin
				next_link.opcode = op_now;
			end
			if (bits == spi_eeprom_pkg::CNT_OP_LAST) begin
				next_link.status = link.st_sync;
				case (op_now)
					spi_eeprom_pkg::OP_READ: next_link.cmd = spi_eeprom_pkg::CMD_READ;
					spi_eeprom_pkg::OP_STATUS_READ: begin
						next_link.cmd = spi_eeprom_pkg::CMD_STATUS_READ;
					end
					spi_eeprom_pkg::OP_WRITE_ENABLE: begin
						next_link.cmd = spi_eeprom_pkg::CMD_WRITE_ENABLE;
					end
					spi_eeprom_pkg::OP_WRITE_DISABLE: begin
						next_link.cmd = spi_eeprom_pkg::CMD_WRITE_DISABLE;
					end
					spi_eeprom_pkg::OP_STATUS_WRITE: begin
						next_link.cmd = spi_eeprom_pkg::CMD_STATUS_WRITE;
					end
					default: next_link.cmd = spi_eeprom_pkg::CMD_NONE;
				endcase
				if (link.st_sync[spi_eeprom_pkg::ST_BUSY]
					&& next_link.cmd != spi_eeprom_pkg::CMD_STATUS_READ) begin
					next_link.cmd = spi_eeprom_pkg::CMD_NONE;
				end
			end
			if (link.cmd == spi_eeprom_pkg::CMD_READ) begin
				if (bits >= spi_eeprom_pkg::CNT_OP_DONE && bits < spi_eeprom_pkg::CNT_ADDR_LAST) begin
					next_link.addr_hi = {link.addr_hi[13:0], i_si};
				end
				if (bits == spi_eeprom_pkg::CNT_ADDR_LAST) begin
					rd_en = 1'b1;
					rd_addr = {link.addr_hi[11:0], i_si};
					next_link.ptr = rd_addr;
				end
				if (bits == spi_eeprom_pkg::CNT_DATA_LAST) begin
					rd_en = 1'b1;
					rd_addr = link.ptr + 13'h0001;
					next_link.ptr = rd_addr;
				end
			end
			if (link.cmd == spi_eeprom_pkg::CMD_STATUS_WRITE && bits >= spi_eeprom_pkg::CNT_OP_DONE
				&& bits <= spi_eeprom_pkg::CNT_ST_LAST) begin
				next_link.wr_data = {link.wr_data[6:0], i_si};
			end
			if (link.cmd == spi_eeprom_pkg::CMD_READ && bits == spi_eeprom_pkg::CNT_DATA_LAST) begin
				next_link.cnt = spi_eeprom_pkg::CNT_DATA_FIRST;
			end else if (link.cmd == spi_eeprom_pkg::CMD_STATUS_READ
				&& bits == spi_eeprom_pkg::CNT_ST_LAST) begin
				next_link.cnt = spi_eeprom_pkg::CNT_OP_DONE;
			end else if (bits != spi_eeprom_pkg::CNT_DATA_LAST) begin
				next_link.cnt = bits + 5'h01;
			end else begin
				next_link.cnt = bits;
			end
		end
		// Exact bit count recorded for the frame end
		next_link.flags.write_enable_cmd = next_link.cmd == spi_eeprom_pkg::CMD_WRITE_ENABLE
			&& next_link.cnt == spi_eeprom_pkg::CNT_OP_DONE;
		next_link.flags.wrdi = next_link.cmd == spi_eeprom_pkg::CMD_WRITE_DISABLE
			&& next_link.cnt == spi_eeprom_pkg::CNT_OP_DONE;
		next_link.flags.wrsr = next_link.cmd == spi_eeprom_pkg::CMD_STATUS_WRITE
			&& next_link.cnt == spi_eeprom_pkg::CNT_SW_DONE;
		next_link.flags.data = next_link.wr_data;
	end

	always_ff @(posedge i_sck or posedge i_rst) begin
		if (i_rst) begin
			link <= '0;
			link.cmd <= spi_eeprom_pkg::CMD_NONE;
		end else begin
			link <= next_link;
		end
	end

	spi_eeprom_array #(
		.ADDR_W(spi_eeprom_pkg::ADDR_BITS),
		.DATA_W(8)
	) u_array (
		.i_wr_clk(i_core_clk),
		.i_wr_en(i_load_en),
		.i_wr_addr(i_load_addr),
		.i_wr_data(i_load_data),
		.i_rd_clk(i_sck),
		.i_rd_en(rd_en),
		.i_rd_addr(rd_addr),
		.o_rd_data(rd_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// Output on the falling edge
	assign out_active = (link.cmd == spi_eeprom_pkg::CMD_READ
		&& link.cnt >= spi_eeprom_pkg::CNT_DATA_FIRST)
		|| (link.cmd == spi_eeprom_pkg::CMD_STATUS_READ
		&& link.cnt >= spi_eeprom_pkg::CNT_OP_DONE);

	always_ff @(negedge i_sck or posedge i_rst or posedge i_cs_n) begin
		if (i_rst || i_cs_n) begin
			so_bit <= 1'b0;
			so_drive <= 1'b0;
		end else if (i_hold_n) begin
			so_drive <= ~armed & out_active;
			if (link.cmd == spi_eeprom_pkg::CMD_READ) begin
				so_bit <= rd_data[~link.cnt[2:0]];
			end else begin
				so_bit <= link.status[~link.cnt[2:0]];
			end
		end
	end

	assign o_so = so_bit;
	assign o_so_oe = ~i_cs_n & i_hold_n & so_drive;

	////////////////////////////////////////////////////////////////////////////
	// Checks, core domain
	a_latch_set_cmd: assert property (@(posedge i_core_clk) disable iff (i_rst)
		$rose(core.write_enable_latch) |-> $past(frame_end) && $past(core.fl_sync.write_enable_cmd))
		else $error("write enable latch set without a command");
	a_hw_protect_blocks: assert property (@(posedge i_core_clk) disable iff (i_rst)
		frame_end && !o_busy && hw_prot && core.fl_sync.wrsr |=> !o_busy)
		else $error("status write started under hardware protection");
	a_wp_fall_aborts: assert property (@(posedge i_core_clk) disable iff (i_rst)
		frame_end && !o_busy && core.wp_fell && core.hw_protect_enable
		&& core.fl_sync.wrsr |=> !o_busy)
		else $error("status write not aborted after protect pin fall");
	a_wp_ignored_off: assert property (@(posedge i_core_clk) disable iff (i_rst)
		frame_fresh && !o_busy && !core.hw_protect_enable && core.write_enable_latch
		&& core.fl_sync.wrsr |=> o_busy)
		else $error("status write refused with protect enable clear");
	a_write_holds: assert property (@(posedge i_core_clk) disable iff (i_rst)
		o_busy && core.wait_cnt != 32'h0000_0000 |=> o_busy)
		else $error("self-timed write ended early");
	a_latch_clears: assert property (@(posedge i_core_clk) disable iff (i_rst)
		$fell(o_busy) |-> !core.write_enable_latch && !status_word[spi_eeprom_pkg::ST_WEL])
		else $error("write enable latch not cleared after write");
	a_start_on_frame: assert property (@(posedge i_core_clk) disable iff (i_rst)
		$rose(o_busy) |-> $past(frame_end) && $past(core.fl_sync.wrsr))
		else $error("write started without a complete status write frame");

	////////////////////////////////////////////////////////////////////////////
	// Checks, link domain
	a_ptr_advance: assert property (@(posedge i_sck) disable iff (i_rst || i_cs_n)
		i_hold_n && !armed && link.cmd == spi_eeprom_pkg::CMD_READ
		&& link.cnt == spi_eeprom_pkg::CNT_DATA_LAST
		|=> link.ptr == 13'($past(link.ptr) + 13'h0001))
		else $error("read pointer did not advance by one");
	a_hold_freezes: assert property (@(posedge i_sck) disable iff (i_rst || i_cs_n)
		!i_hold_n && !armed |-> !o_so_oe ##1 (link.cnt == $past(link.cnt)))
		else $error("state moved during hold");
	a_invalid_quiet: assert property (@(posedge i_sck) disable iff (i_rst || i_cs_n)
		!armed && link.cmd == spi_eeprom_pkg::CMD_NONE
		&& link.cnt >= spi_eeprom_pkg::CNT_OP_DONE |-> !so_drive)
		else $error("output driven for an ignored frame");

	c_read_data: cover property (@(posedge i_sck) disable iff (i_rst || i_cs_n)
		link.cmd == spi_eeprom_pkg::CMD_READ && link.cnt == spi_eeprom_pkg::CNT_DATA_LAST);
	c_status_busy: cover property (@(posedge i_sck) disable iff (i_rst || i_cs_n)
		link.cmd == spi_eeprom_pkg::CMD_STATUS_READ && link.status[spi_eeprom_pkg::ST_BUSY]);
	c_hold: cover property (@(posedge i_sck) disable iff (i_rst || i_cs_n) !i_hold_n);
	c_write_start: cover property (@(posedge i_core_clk) disable iff (i_rst) $rose(o_busy));
endmodule : spi_eeprom_read_hold_protect

/* File: spi_host_model.sv */
// Purpose: Behavioural host controller on the serial pins of the EEPROM engine
// Assumes: Link clock period 30 ns, standing still between frames
// Notes: A released output line reads as the inverse of the last sampled bit
`timescale 1ns/100ps
module spi_host_model (
	// Serial pins towards the device
	output logic o_sck,
	output logic o_cs_n,
	output logic o_si,
	output logic o_hold_n,
	// Device output
	input wire logic i_so,
	input wire logic i_so_oe
);
	localparam realtime HALF = 15.0;
	logic [64:0] result;
	logic hold_oe;
	logic last_bit;
	event done;

	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_si = 1'b0;
		o_hold_n = 1'b1;
		last_bit = 1'b0;
		hold_oe = 1'b0;
		result = '0;
	end

	////////////////////////////////////////////////////////////////////////////
	// One framed transfer; result holds {output seen, received bits}
	task automatic frame(input int nbits, input logic [63:0] tx, input logic cpol,
		input int hold_at);
		logic seen;
		logic [63:0] rx;
		seen = 1'b0;
		rx = '0;
		hold_oe = 1'b0;
		#3.3;
		o_sck = cpol;
		#HALF;
		o_cs_n = 1'b0;
		#HALF;
		for (int i = 0; i < nbits; i++) begin
			o_sck = 1'b0;
			if (i == hold_at) begin
				#5 o_hold_n = 1'b0;
				// Clock and input keep moving while paused
				repeat (2) begin
					#HALF o_sck = 1'b1;
					hold_oe = hold_oe | i_so_oe;
					#HALF o_sck = 1'b0;
					o_si = ~o_si;
				end
				#5 o_hold_n = 1'b1;
			end
			o_si = tx[nbits-1-i];
			#HALF;
			o_sck = 1'b1;
			last_bit = i_so_oe ? i_so : ~last_bit;
			rx = {rx[62:0], last_bit};
			seen = seen | i_so_oe;
			#HALF;
		end
		o_sck = cpol;
		#HALF;
		o_cs_n = 1'b1;
		#HALF;
		result = {seen, rx};
		->done;
	endtask : frame
endmodule : spi_host_model

/* File: spi_eeprom_read_hold_protect_test.sv */
// Purpose: Self-checking bench of the serial EEPROM command engine
// Assumes: Self-timed write shortened to a few microseconds
// Notes: Frame results are compared against queued notes by a monitor
`timescale 1ns/100ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin bad_count++; \
	$display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module spi_eeprom_read_hold_protect_test;
	localparam int WCYC = 600;
	typedef struct packed {
		logic [64:0] val;
		logic [64:0] mask;
	} note_t;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic sck, cs_n, si, hold_n, so, so_oe, busy;
	logic wp_n = 1'b1;
	logic load_en = 1'b0;
	logic [12:0] load_addr = '0;
	logic [7:0] load_data = '0;
	logic [7:0] status;
	logic [7:0] mem [0:8191];
	note_t exp_q [$];
	note_t cur;
	int bad_count = 0;
	int cmp_count = 0;
	int seed = 39;

	always #2.5 core_clk = ~core_clk;

	spi_eeprom_read_hold_protect #(.WRITE_CYCLES(WCYC)) dut_u (
		.i_core_clk(core_clk), .i_rst(rst), .i_sck(sck), .i_cs_n(cs_n), .i_si(si),
		.i_hold_n(hold_n), .i_wp_n(wp_n), .o_so(so), .o_so_oe(so_oe),
		.i_load_en(load_en), .i_load_addr(load_addr), .i_load_data(load_data),
		.o_status(status), .o_busy(busy));

	spi_host_model host_u (
		.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .o_hold_n(hold_n),
		.i_so(so), .i_so_oe(so_oe));

	////////////////////////////////////////////////////////////////////////////
	// Tasks
	task automatic finish_test();
		$display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test

	task automatic core_wait(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : core_wait

	task automatic note(input logic [64:0] v, input logic [64:0] m);
		exp_q.push_back('{v, m});
	endtask : note

	task automatic load(input logic [12:0] a);
		load_addr = a;
		load_data = 8'($random(seed));
		mem[a] = load_data;
		load_en = 1'b1;
		core_wait(1);
		load_en = 1'b0;
		core_wait(1);
	endtask : load

	// Frame that must never enable the output
	task automatic cmd(input int n, input logic [63:0] tx);
		note(65'h0, 65'h1 << 64);
		host_u.frame(n, tx, 1'b0, -1);
		core_wait(6);
	endtask : cmd

	task automatic rd_status(input logic [7:0] e);
		note({1'b1, 56'h0, e}, {1'b1, 56'h0, 8'hff});
		host_u.frame(16, {48'h0, spi_eeprom_pkg::OP_STATUS_READ, 8'h00}, 1'b0, -1);
		core_wait(6);
	endtask : rd_status

	task automatic rd_array(input logic [15:0] a, input int n, input logic cpol,
		input int hold);
		logic [64:0] v;
		logic [64:0] m;
		v = 65'h1 << 64;
		m = v;
		for (int k = 0; k < n; k++) begin
			v[63:0] = {v[55:0], mem[(a[12:0] + k) % 8192]};
			m[63:0] = {m[55:0], 8'hff};
		end
		note(v, m);
		host_u.frame(24 + 8 * n, {40'h0, spi_eeprom_pkg::OP_READ, a} << (8 * n), cpol, hold);
		core_wait(6);
		`CHK(so_oe, 1'b0)
	endtask : rd_array

	task automatic wait_idle();
		for (int i = 0; i < 2 * WCYC && busy !== 1'b0; i++)
			core_wait(1);
		if (busy !== 1'b0) begin
			bad_count++;
			finish_test();
		end
	endtask : wait_idle

	////////////////////////////////////////////////////////////////////////////
	// Monitor: each finished frame takes the oldest note
	always @(host_u.done) begin
		if (exp_q.size() == 0) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, host_u.result, 65'h0);
		end else begin
			cur = exp_q.pop_front();
			`CHK(host_u.result & cur.mask, cur.val)
		end
	end

	initial begin
		#300000;
		bad_count++;
		finish_test();
	end

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (3) @(posedge core_clk);
		#1 rst = 1'b0;
		core_wait(4);
		`CHK(status, 8'h00)
		`CHK(busy, 1'b0)
		`CHK(so_oe, 1'b0)
		$display("Test reset done");
		load(13'h1ffe);
		load(13'h1fff);
		load(13'h0000);
		load(13'h0001);
		load(13'h0005);
		rd_array(16'he005, 1, 1'b1, 12);
		rd_array(16'h1ffe, 4, 1'b0, 28);
		`CHK(host_u.hold_oe, 1'b0)
		$display("Test array read done");
		rd_status(8'h00);
		cmd(8, {56'h0, spi_eeprom_pkg::OP_WRITE_ENABLE});
		rd_status(8'h02);
		wp_n = 1'b0;
		cmd(16, {48'h0, spi_eeprom_pkg::OP_STATUS_WRITE, 8'h8c});
		`CHK(busy, 1'b1)
		rd_status(8'h03);
		cmd(32, {32'h0, spi_eeprom_pkg::OP_READ, 16'h0000, 8'h00});
		wait_idle();
		rd_status(8'h8c);
		$display("Test status write done");
		cmd(8, {56'h0, spi_eeprom_pkg::OP_WRITE_ENABLE});
		cmd(16, {48'h0, spi_eeprom_pkg::OP_STATUS_WRITE, 8'h00});
		`CHK(busy, 1'b0)
		`CHK(status & 8'h8c, 8'h8c)
		wp_n = 1'b1;
		cmd(8, {56'h0, spi_eeprom_pkg::OP_WRITE_ENABLE});
		fork
			cmd(16, {48'h0, spi_eeprom_pkg::OP_STATUS_WRITE, 8'h00});
			begin
				core_wait(40);
				wp_n = 1'b0;
				core_wait(20);
				wp_n = 1'b1;
			end
		join
		`CHK(busy, 1'b0)
		cmd(8, {56'h0, spi_eeprom_pkg::OP_WRITE_ENABLE});
		cmd(15, {49'h0, spi_eeprom_pkg::OP_STATUS_WRITE, 7'h42});
		`CHK(busy, 1'b0)
		cmd(16, {48'h0, spi_eeprom_pkg::OP_STATUS_WRITE, 8'h84});
		`CHK(busy, 1'b1)
		wp_n = 1'b0;
		wait_idle();
		rd_status(8'h84);
		$display("Test protect done");
		cmd(24, {40'h0, 8'hff, 16'h0000});
		`CHK(so_oe, 1'b0)
		`CHK(exp_q.size(), 0)
		$display("Test unknown op-code done");
		finish_test();
	end
endmodule : spi_eeprom_read_hold_protect_test
